// >>> src/fwi_top.sv
// Fault latch, warning word and front-panel indication with Avalon-MM registers
//
// What this block does
// - Fault codes 0..5: parameter, output stage, safety (only when enabled), bus, encoder, supply.
// - Fault codes 6..9: motor temp, device temp, overvoltage, over-current.
// - Fault codes A..F: runaway, user, bleeder, firmware mismatch, current sense, ballast.
// - Latched fault lights red indicator and shows its code.
// - Fault opens ready relay, drops ready message and ready flag.
// - Removing enable alone never clears a latched fault.
// - Cancel request via input or CAN while enabled clears the fault once no fault cause is present.
// - Supply up with enable active: red indicator, no code shown.
// - Warning bits 16, 17, 18: identity, run signal, field enable.
// - Warning bits 21..25: supply, temperatures, overvoltage, over-current.
// - Warning bits 28 and 31; bits 19,20,26,27,29,30 stay zero.
// - Warning: red indicator toggles slowly, display alternates number and state.
// - Normal state: green display and point show operating state.
// - Point flashes while processor runs; dark without supply or on hardware fault.
// - After power-up a flashing start pattern shows until first drive enable.
// - Enable segment lit while drive okay and enabled.
// - Standstill segment when speed zero, else direction segment.
// - Current segment flashes at continuous limit, lit at max, else dark.
`timescale 1ns/1ps
module fwi_top #(
  parameter int unsigned FLASH_CYCLES = fwi_pkg::FLASH_CYCLES,
  parameter int unsigned ALT_CYCLES = fwi_pkg::ALT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave, byte addressed
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Fault and warning causes (pins)
  input wire logic [15:0] fault_cause,
  input wire logic [15:0] warn_cause,
  // Drive condition pins
  input wire logic hardware_enable_input,
  input wire logic aux_supply_ok,
  input wire logic hw_internal_fault,
  input wire logic processor_run,
  input wire logic drive_ok,
  input wire logic drive_enable,
  input wire logic speed_zero,
  input wire logic turn_cw,
  input wire logic cont_current_limit,
  input wire logic max_current_limit,
  input wire logic cancel_din,
  // Cancel request from the CAN logic, same clock
  input wire logic cancel_can,
  // Indication
  output logic fault_led,
  output logic ready_relay,
  output logic ready_flag,
  output logic [6:0] seg,
  output logic seg_dp,
  output logic seg_green,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [15:0] fault_s;
  logic [15:0] warn_s;
  logic hw_en_s;
  logic aux_s;
  logic hwfail_s;
  logic run_s;
  logic ok_s;
  logic ena_s;
  logic zero_s;
  logic cw_s;
  logic cont_s;
  logic max_s;
  logic cancel_s;

  fwi_sync #(.W(43)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin({fault_cause, warn_cause, hardware_enable_input, aux_supply_ok,
          hw_internal_fault, processor_run, drive_ok, drive_enable, speed_zero,
          turn_cw, cont_current_limit, max_current_limit, cancel_din}),
    .level({fault_s, warn_s, hw_en_s, aux_s, hwfail_s, run_s, ok_s, ena_s,
            zero_s, cw_s, cont_s, max_s, cancel_s})
  );

  fwi_tick_if tick ();

  fwi_blink #(.FLASH_CYCLES(FLASH_CYCLES), .ALT_CYCLES(ALT_CYCLES)) u_blink (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic ballast_fitted;
  logic fault_latched;
  logic [3:0] code;
  logic [31:0] warn_word;
  logic start_err;
  logic startup_flash;
  logic [1:0] boot_cnt;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic rd_ack;
  logic warn_any_q;

  logic [15:0] fault_hit;
  logic cancel_req;
  logic fault_clear;
  logic fault_set;
  logic warn_any;
  logic [6:0] state_seg;
  logic [6:0] next_seg;
  logic next_led;
  logic next_green;
  logic next_dp;
  logic [2:0] irq_event;
  logic [7:0] idx;
  logic wr_stat;

  // Safety fault only counts while run enable is active; ballast only when fitted
  always_comb begin
    fault_hit = fault_s;
    fault_hit[fwi_pkg::FAULT_SAFETY] = fault_s[fwi_pkg::FAULT_SAFETY] & hw_en_s;
    fault_hit[fwi_pkg::FAULT_BALLAST] = fault_s[fwi_pkg::FAULT_BALLAST] & ballast_fitted;
  end

  // Clear needs enable; a cause still present keeps the fault (set wins)
  assign cancel_req = cancel_s | cancel_can;
  assign fault_clear = fault_latched & cancel_req & hw_en_s & ~(|fault_hit);
  assign fault_set = ~fault_latched & (|fault_hit);

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch; only a cancel clears it, never loss of enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_latched <= 1'b0;
      code <= 4'h0;
    end else if (fault_set) begin
      fault_latched <= 1'b1;
      code <= fwi_pkg::fwi_first(fault_hit);
    end else if (fault_clear) begin
      fault_latched <= 1'b0;
    end
  end

  // Warning word, unused positions forced to zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warn_word <= 32'h0;
    end else begin
      warn_word <= {warn_s & fwi_pkg::WARN_USED, 16'h0};
    end
  end

  assign warn_any = |warn_word;

  // Power-up capture of enable once the pin chain has settled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_cnt <= 2'h0;
      start_err <= 1'b0;
    end else if (boot_cnt != fwi_pkg::BOOT_CYCLES + 2'h1) begin
      boot_cnt <= boot_cnt + 2'h1;
      // Synced level is only valid once the chain has been filled
      if (boot_cnt == fwi_pkg::BOOT_CYCLES) begin
        start_err <= hw_en_s;
      end
    end else if (!hw_en_s) begin
      start_err <= 1'b0;
    end
  end

  // Start pattern until the first drive enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startup_flash <= 1'b1;
    end else if (ok_s && ena_s) begin
      startup_flash <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating state pattern
  always_comb begin
    state_seg = 7'h0;
    if (startup_flash) begin
      state_seg = tick.flash ? fwi_pkg::SEG_START : 7'h0;
    end else begin
      state_seg[fwi_pkg::SEG_D] = ok_s & ena_s;
      state_seg[fwi_pkg::SEG_G] = zero_s;
      state_seg[fwi_pkg::SEG_C] = ~zero_s & cw_s;
      state_seg[fwi_pkg::SEG_E] = ~zero_s & ~cw_s;
      state_seg[fwi_pkg::SEG_A] = cont_s ? tick.flash : max_s;
    end
  end

  // Priority: fault, then start error, then warning, then normal
  always_comb begin
    next_seg = state_seg;
    next_led = 1'b0;
    next_green = 1'b0;
    if (fault_latched) begin
      next_seg = fwi_pkg::fwi_hex7(code);
      next_led = 1'b1;
    end else if (start_err) begin
      next_seg = 7'h0;
      next_led = 1'b1;
    end else if (warn_any) begin
      next_led = tick.alt;
      if (tick.alt) begin
        next_seg = fwi_pkg::fwi_hex7(fwi_pkg::fwi_first(warn_word[31:16]));
      end
    end else begin
      next_green = 1'b1;
    end
  end

  // Point dark without supply or on internal failure
  assign next_dp = aux_s & ~hwfail_s & run_s & tick.flash;

  // Display and ready outputs from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seg <= 7'h0;
      seg_dp <= 1'b0;
      seg_green <= 1'b0;
      fault_led <= 1'b0;
      ready_relay <= 1'b0;
      ready_flag <= 1'b0;
    end else begin
      seg <= next_seg;
      seg_dp <= next_dp;
      seg_green <= next_green;
      fault_led <= next_led;
      ready_relay <= ~fault_latched & ok_s;
      ready_flag <= ~fault_latched & ok_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events, sticky status, set beats clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warn_any_q <= 1'b0;
    end else begin
      warn_any_q <= warn_any;
    end
  end

  always_comb begin
    irq_event = 3'h0;
    irq_event[fwi_pkg::IRQ_FAULT_SET] = fault_set;
    irq_event[fwi_pkg::IRQ_WARN_SET] = warn_any & ~warn_any_q;
    irq_event[fwi_pkg::IRQ_FAULT_CLR] = fault_clear;
  end

  assign idx = address[9:2];
  assign wr_stat = write & byteenable[0] & (idx == fwi_pkg::IDX_IRQ_STAT);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat <= 3'h0;
    end else if (wr_stat) begin
      irq_stat <= (irq_stat & ~writedata[2:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, low byte only; unmapped writes dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ballast_fitted <= fwi_pkg::CTRL_RESET;
      irq_mask <= fwi_pkg::IRQ_MASK_RESET;
    end else if (write && byteenable[0]) begin
      if (idx == fwi_pkg::IDX_CTRL) begin
        ballast_fitted <= writedata[0];
      end
      if (idx == fwi_pkg::IDX_IRQ_MASK) begin
        irq_mask <= writedata[2:0];
      end
    end
  end

  // Reads take one wait cycle; unmapped reads return zero
  assign waitrequest = read & ~rd_ack;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_ack <= 1'b0;
      readdata <= 32'h0;
    end else begin
      rd_ack <= read & ~rd_ack;
      if (read && !rd_ack) begin
        case (idx)
          fwi_pkg::IDX_WARN: readdata <= warn_word;
          fwi_pkg::IDX_CTRL: readdata <= {31'h0, ballast_fitted};
          fwi_pkg::IDX_IRQ_STAT: readdata <= {29'h0, irq_stat};
          fwi_pkg::IDX_IRQ_MASK: readdata <= {29'h0, irq_mask};
          fwi_pkg::IDX_FAULT: readdata <= {24'h0, startup_flash, start_err,
                                           ~fault_latched & ok_s, fault_latched, code};
          default: readdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_drive_on;
    ok_s && ena_s;
  endsequence

  sequence s_fault_held;
    fault_latched && !(cancel_req && hw_en_s);
  endsequence

  a_safety_gated: assert property (
    (!fault_latched && fault_s == 16'h0004 && !hw_en_s) |=> !fault_latched)
    else $error("safety fault latched without enable");

  a_fault_code: assert property (
    fault_latched |=> seg == fwi_pkg::fwi_hex7($past(code)) && fault_led)
    else $error("fault code not shown");

  a_fault_ready: assert property (
    fault_latched ##1 fault_latched |-> !ready_relay && !ready_flag)
    else $error("ready asserted during fault");

  a_fault_hold: assert property (
    s_fault_held |=> fault_latched)
    else $error("fault cleared without cancel");

  a_clear_cause: assert property (
    $fell(fault_latched) |-> $past(cancel_req && hw_en_s))
    else $error("fault cleared without enabled cancel");

  a_start_dark: assert property (
    (start_err && !fault_latched) |=> seg == 7'h0 && fault_led)
    else $error("start error display wrong");

  a_warn_reserved: assert property (
    (warn_word & ~{fwi_pkg::WARN_USED, 16'h0}) == 32'h0)
    else $error("reserved warning bit set");

  a_warn_led: assert property (
    (warn_any && !fault_latched && !start_err) |=> fault_led == $past(tick.alt))
    else $error("warning indicator out of phase");

  a_prio_green: assert property (
    (fault_latched || warn_any) |=> !seg_green)
    else $error("green shown during fault or warning");

  a_dp_dark: assert property (
    (!aux_s || hwfail_s) |=> !seg_dp)
    else $error("point lit without supply");

  a_start_stop: assert property (
    s_drive_on |=> !startup_flash)
    else $error("start pattern kept after enable");

  a_enable_seg: assert property (
    (!fault_latched && !start_err && !warn_any && !startup_flash)
      |=> seg[fwi_pkg::SEG_D] == $past(ok_s && ena_s))
    else $error("enable segment wrong");

endmodule // fwi_top

// >>> src/fwi_pkg.sv
// Shared constants, register map and display helpers for the fault indicator
package fwi_pkg;

  // Clock rate and chosen flash / alternation times
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned ALT_MS = 500;
  localparam int unsigned FLASH_CYCLES = FLASH_MS * CLK_MHZ * 1000;
  localparam int unsigned ALT_CYCLES = ALT_MS * CLK_MHZ * 1000;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WARN = 8'h8f;
  localparam logic [7:0] IDX_CTRL = 8'h90;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h91;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h92;
  localparam logic [7:0] IDX_FAULT = 8'h93;

  // Reset values
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Interrupt status bit positions
  localparam int IRQ_FAULT_SET = 0;
  localparam int IRQ_WARN_SET = 1;
  localparam int IRQ_FAULT_CLR = 2;

  // Fault cause positions that need gating
  localparam int FAULT_SAFETY = 2;
  localparam int FAULT_BALLAST = 15;

  // Warning word: causes occupy bits 16..31, unused bits never set
  localparam int WARN_BASE = 16;
  localparam logic [15:0] WARN_USED = 16'h93e7;

  // Seven-segment bit positions
  localparam int SEG_A = 0;
  localparam int SEG_C = 2;
  localparam int SEG_D = 3;
  localparam int SEG_E = 4;
  localparam int SEG_G = 6;
  localparam logic [6:0] SEG_START = 7'h3f;

  // Cycles after reset release before the synchronised pins are valid
  localparam logic [1:0] BOOT_CYCLES = 2'h2;

  // Hex digit to segments a..g, active high
  function automatic logic [6:0] fwi_hex7(input logic [3:0] d);
    case (d)
      4'h0: fwi_hex7 = 7'h3f;
      4'h1: fwi_hex7 = 7'h06;
      4'h2: fwi_hex7 = 7'h5b;
      4'h3: fwi_hex7 = 7'h4f;
      4'h4: fwi_hex7 = 7'h66;
      4'h5: fwi_hex7 = 7'h6d;
      4'h6: fwi_hex7 = 7'h7d;
      4'h7: fwi_hex7 = 7'h07;
      4'h8: fwi_hex7 = 7'h7f;
      4'h9: fwi_hex7 = 7'h6f;
      4'ha: fwi_hex7 = 7'h77;
      4'hb: fwi_hex7 = 7'h7c;
      4'hc: fwi_hex7 = 7'h39;
      4'hd: fwi_hex7 = 7'h5e;
      4'he: fwi_hex7 = 7'h79;
      default: fwi_hex7 = 7'h71;
    endcase
  endfunction

  // Index of the lowest set bit
  function automatic logic [3:0] fwi_first(input logic [15:0] v);
    fwi_first = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        fwi_first = 4'(i);
      end
    end
  endfunction

endpackage

// >>> src/fwi_tick_if.sv
// Flash and alternation phases shared between the timer and the display logic
`timescale 1ns/1ps
interface fwi_tick_if;
  logic flash;
  logic alt;
  modport gen (output flash, output alt);
  modport use_side (input flash, input alt);
endinterface

// >>> src/fwi_sync.sv
// Two-stage synchroniser, one chain per pin bit
`timescale 1ns/1ps
module fwi_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pins in, synchronised levels out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] stage1;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        stage1[i] <= 1'b0;
        level[i] <= 1'b0;
      end else begin
        stage1[i] <= pin[i];
        level[i] <= stage1[i];
      end
    end
  end

endmodule // fwi_sync

// >>> src/fwi_blink.sv
// Flash and warning-alternation phase generator
`timescale 1ns/1ps
module fwi_blink #(
  parameter int unsigned FLASH_CYCLES = fwi_pkg::FLASH_CYCLES,
  parameter int unsigned ALT_CYCLES = fwi_pkg::ALT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Phases out
  fwi_tick_if.gen tick
);

  logic [31:0] flash_cnt;
  logic [31:0] alt_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Fast flash phase, half period each
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_cnt <= 32'h0;
      tick.flash <= 1'b0;
    end else if (flash_cnt >= 32'(FLASH_CYCLES - 1)) begin
      flash_cnt <= 32'h0;
      tick.flash <= ~tick.flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  // Slow alternation phase; starts on the warning number side
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alt_cnt <= 32'h0;
      tick.alt <= 1'b1;
    end else if (alt_cnt >= 32'(ALT_CYCLES - 1)) begin
      alt_cnt <= 32'h0;
      tick.alt <= ~tick.alt;
    end else begin
      alt_cnt <= alt_cnt + 32'h1;
    end
  end

endmodule // fwi_blink

// >>> tb/fwi_field_model.sv
// Field side model: hardware enable line and digital cancel input
`timescale 1ns/1ps
module fwi_field_model (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic hw_en_cmd,
  input wire logic cancel_cmd,
  // Pins towards the drive
  output logic hardware_enable_input,
  output logic cancel_din
);
  logic [2:0] cancel_cnt = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Enable follows the command; no reset so it can be high at power-up
  always_ff @(posedge clock) begin
    hardware_enable_input <= hw_en_cmd;
  end

  // Cancel is issued only while enabled and held long enough to pass the sync
  always_ff @(posedge clock) begin
    if (cancel_cmd && hardware_enable_input) begin
      cancel_cnt <= 3'h4;
    end else if (cancel_cnt != 3'h0) begin
      cancel_cnt <= cancel_cnt - 3'h1;
    end
  end

  assign cancel_din = (cancel_cnt != 3'h0);
endmodule // fwi_field_model

// >>> tb/tb.sv
// Self-checking bench for the fault and warning indicator
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [9:0] address = 10'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] fault_cause = 16'h0;
  logic [15:0] warn_cause = 16'h0;
  logic hw_en_cmd = 1'b1;
  logic cancel_cmd = 1'b0;
  logic hardware_enable_input, cancel_din;
  logic aux_supply_ok = 1'b1;
  logic hw_internal_fault = 1'b0;
  logic processor_run = 1'b1;
  logic drive_ok = 1'b0;
  logic drive_enable = 1'b0;
  logic speed_zero = 1'b0;
  logic turn_cw = 1'b0;
  logic cont_current_limit = 1'b0;
  logic max_current_limit = 1'b0;
  logic cancel_can = 1'b0;
  logic fault_led, ready_relay, ready_flag, seg_dp, seg_green, irq;
  logic [6:0] seg;
  logic [31:0] rd;
  logic s1, s0;
  int mismatches = 0;
  int checked = 0;
  // Own copy of the digit patterns, segments a..g
  logic [6:0] hex_tab [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                               7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

  // 200 MHz clock
  always #2.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Short flash periods keep the run brief
  fwi_top #(.FLASH_CYCLES(4), .ALT_CYCLES(8)) u_fwi_top (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .fault_cause(fault_cause), .warn_cause(warn_cause),
    .hardware_enable_input(hardware_enable_input), .aux_supply_ok(aux_supply_ok),
    .hw_internal_fault(hw_internal_fault), .processor_run(processor_run),
    .drive_ok(drive_ok), .drive_enable(drive_enable), .speed_zero(speed_zero),
    .turn_cw(turn_cw), .cont_current_limit(cont_current_limit),
    .max_current_limit(max_current_limit), .cancel_din(cancel_din),
    .cancel_can(cancel_can), .fault_led(fault_led), .ready_relay(ready_relay),
    .ready_flag(ready_flag), .seg(seg), .seg_dp(seg_dp), .seg_green(seg_green), .irq(irq));

  fwi_field_model u_fwi_field_model (
    .clock(clock), .hw_en_cmd(hw_en_cmd), .cancel_cmd(cancel_cmd),
    .hardware_enable_input(hardware_enable_input), .cancel_din(cancel_din));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task final_report;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task cycles(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Avalon access, called just after a rising edge; waitrequest and data taken at the
  // rising edge, request held until then, one idle edge before the next request
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] d);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    writedata <= wd;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
    if (n >= 100) begin
      mismatches++;
      final_report();
    end
  endtask

  // Watch one output for 40 cycles; sel 0 led, 1 current segment, 2 point
  task watch(input int sel, output logic saw1, output logic saw0);
    logic v;
    saw1 = 1'b0;
    saw0 = 1'b0;
    repeat (40) begin
      @(posedge clock);
      v = (sel == 0) ? fault_led : (sel == 1) ? seg[0] : seg_dp;
      if (v === 1'b1) saw1 = 1'b1;
      if (v === 1'b0) saw0 = 1'b1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Enable already high at power-up: red led, blank display
  task t_start_error;
    cycles(6);
    check(fault_led, 1);
    check(seg, 0);
    bus(0, 8'h93, 0, rd);
    check(rd[6], 1);
    hw_en_cmd <= 1'b0;
    cycles(8);
    check(fault_led, 0);
  endtask

  // Reset values, unmapped place, start pattern until first enable
  task t_regs_start;
    bus(0, 8'h90, 0, rd);
    check(rd, 0);
    bus(0, 8'h92, 0, rd);
    check(rd, 0);
    bus(1, 8'hff, 32'hffffffff, rd);
    bus(0, 8'hff, 0, rd);
    check(rd, 0);
    bus(0, 8'h93, 0, rd);
    check(rd[7], 1);
    watch(1, s1, s0);
    check({s1, s0}, 2'b11);
    drive_ok <= 1'b1;
    drive_enable <= 1'b1;
    cycles(8);
    bus(0, 8'h93, 0, rd);
    check(rd[7], 0);
    check(seg[3], 1);
  endtask

  // Normal state segments, point and current indication
  task t_normal;
    check(seg_green, 1);
    check({ready_relay, ready_flag}, 2'b11);
    speed_zero <= 1'b1;
    cycles(6);
    check({seg[6], seg[4], seg[2]}, 3'b100);
    speed_zero <= 1'b0;
    turn_cw <= 1'b1;
    cycles(6);
    check({seg[6], seg[4], seg[2]}, 3'b001);
    turn_cw <= 1'b0;
    max_current_limit <= 1'b1;
    cycles(6);
    check({seg[6], seg[4], seg[2], seg[0]}, 4'b0101);
    cont_current_limit <= 1'b1;
    watch(1, s1, s0);
    check({s1, s0}, 2'b11);
    max_current_limit <= 1'b0;
    cont_current_limit <= 1'b0;
    watch(2, s1, s0);
    check({s1, s0, seg[0]}, 3'b110);
    aux_supply_ok <= 1'b0;
    cycles(4);
    watch(2, s1, s0);
    check({s1, s0}, 2'b01);
    aux_supply_ok <= 1'b1;
    hw_internal_fault <= 1'b1;
    cycles(4);
    watch(2, s1, s0);
    check({s1, s0}, 2'b01);
    hw_internal_fault <= 1'b0;
    drive_enable <= 1'b0;
    cycles(6);
    check(seg[3], 0);
    drive_enable <= 1'b1;
  endtask

  // Every fault code latched and cleared by cancel, code 0 also held without enable
  task t_faults;
    hw_en_cmd <= 1'b1;
    bus(1, 8'h92, 32'h5, rd);
    bus(1, 8'h90, 32'h1, rd);
    for (int c = 0; c < 16; c++) begin
      fault_cause <= 16'h1 << c;
      cycles(6);
      check(seg, hex_tab[c]);
      check({fault_led, ready_relay, ready_flag, irq}, 4'b1001);
      bus(0, 8'h93, 0, rd);
      check(rd[5:0], {2'b01, 4'(c)});
      if (c == 0) begin
        // Cause gone and enable off first, so only the missing enable blocks the cancel
        fault_cause <= 16'h0;
        hw_en_cmd <= 1'b0;
        cycles(6);
        cancel_can <= 1'b1;
        cycles(2);
        cancel_can <= 1'b0;
        cycles(4);
        check({fault_led, seg}, {1'b1, hex_tab[0]});
        hw_en_cmd <= 1'b1;
      end
      fault_cause <= 16'h0;
      cycles(4);
      cancel_cmd <= 1'b1;
      @(posedge clock);
      cancel_cmd <= 1'b0;
      cycles(10);
      check({fault_led, ready_relay}, 2'b01);
      bus(1, 8'h91, 32'h7, rd);
      check(irq, 0);
    end
    // Enable must be seen low before the safety cause arrives
    hw_en_cmd <= 1'b0;
    cycles(4);
    fault_cause <= 16'h0004;
    cycles(8);
    check(fault_led, 0);
    bus(1, 8'h90, 32'h0, rd);
    hw_en_cmd <= 1'b1;
    fault_cause <= 16'h8000;
    cycles(8);
    check(fault_led, 0);
    fault_cause <= 16'h0;
  endtask

  // Warning word layout, alternation, priority of fault over warning
  task t_warn;
    warn_cause <= 16'hffff;
    cycles(4);
    bus(0, 8'h8f, 0, rd);
    check(rd, 32'h93e70000);
    warn_cause <= 16'h0020;
    cycles(6);
    s1 = 1'b0;
    s0 = 1'b0;
    repeat (40) begin
      @(posedge clock);
      if (fault_led === 1'b1) begin
        s1 = 1'b1;
        check(seg, hex_tab[5]);
      end else begin
        s0 = 1'b1;
      end
      check(seg_green, 0);
    end
    check({s1, s0}, 2'b11);
    fault_cause <= 16'h0002;
    cycles(6);
    watch(0, s1, s0);
    check({s1, s0, seg}, {2'b10, hex_tab[1]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cycles(2);
    rst <= 1'b0;
    t_start_error();
    t_regs_start();
    t_normal();
    t_faults();
    t_warn();
    final_report();
  end
endmodule // tb
